// *** design/hbd_fifo.sv ***
// Synchronous FIFO with valid/ready on both sides.
module hbd_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 8
) (
    input  wire logic             clk,      // System clock.
    input  wire logic             rst_n,    // Synchronous reset, active low.
    input  wire logic             inValid,  // Producer offers a word.
    output logic                  inReady,  // Room for a word.
    input  wire logic [WIDTH-1:0] inData,   // Word to store.
    output logic                  outValid, // A word is waiting.
    input  wire logic             outReady, // Consumer takes the word.
    output logic      [WIDTH-1:0] outData   // Oldest word.
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wrPtr_r;
    logic [AW-1:0]    rdPtr_r;
    logic [AW:0]      count_r;
    wire              push = inValid & inReady;
    wire              pop  = outValid & outReady;

    assign inReady  = (count_r != (AW+1)'(DEPTH));
    assign outValid = (count_r != '0);
    assign outData  = mem[rdPtr_r];

    function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
        bump = (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
    endfunction : bump

    always_ff @(posedge clk) begin
        if (push) begin
            mem[wrPtr_r] <= inData;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            wrPtr_r <= '0;
            rdPtr_r <= '0;
            count_r <= '0;
        end else begin
            if (push) begin
                wrPtr_r <= bump(wrPtr_r);
            end
            if (pop) begin
                rdPtr_r <= bump(rdPtr_r);
            end
            count_r <= count_r + (AW+1)'(push) - (AW+1)'(pop);
        end
    end

endmodule : hbd_fifo

// *** design/host_bus_dma_request_port.sv ***
// Parallel host data port with DMA request routing and a write FIFO.
module host_bus_dma_request_port
    import hbd_pkg::*;
(
    input  wire logic                      clk,        // 200 MHz clock.
    input  wire logic                      rst_n,      // Sync reset, low.
    input  wire logic [hbd_pkg::DATA_W-1:0] busIn,     // Data pins in.
    output logic      [hbd_pkg::DATA_W-1:0] busOut,    // Data pins out.
    output logic                           busOe,      // Data pins driven.
    input  wire logic                      chipSelN,   // Chip select, low.
    input  wire logic                      readN,      // Read strobe, low.
    input  wire logic                      writeN,     // Write strobe, low.
    input  wire logic [hbd_pkg::DATA_W-1:0] rdData,    // Word to return.
    output logic                           rdTaken,    // Read started.
    output logic                           wrValid,    // FIFO word ready.
    input  wire logic                      wrReady,    // Sink takes word.
    output logic      [hbd_pkg::DATA_W-1:0] wrData,    // FIFO word.
    output logic                           wrSpace,    // FIFO has room.
    output logic                           wrOverflow, // Write lost, sticky.
    input  wire logic                      hcNeed,     // Host ctrl wants DMA.
    input  wire logic                      dcNeed,     // Periph ctrl wants DMA.
    input  wire logic                      sharedDma,  // Shared channel bit.
    input  wire logic                      hcReqHigh,  // Req1 active high.
    input  wire logic                      hcAckHigh,  // Ack1 active high.
    input  wire logic                      dcReqHigh,  // Req2 active high.
    input  wire logic                      dcAckHigh,  // Ack2 active high.
    input  wire logic                      dmaAck1,    // First ack pin.
    input  wire logic                      dmaAck2,    // Second ack pin.
    output logic                           dmaReq1,    // First request pin.
    output logic                           dmaReq2,    // Second request pin.
    output logic                           hcGrant,    // Host ctrl granted.
    output logic                           dcGrant     // Periph ctrl granted.
);
    import hbd_pkg::*;

    // =========================================================================
    // Pin synchronisers: a change counts once stages two and three agree.
    logic [PIN_W-1:0] s1_r;
    logic [PIN_W-1:0] s2_r;
    logic [PIN_W-1:0] s3_r;
    logic [PIN_W-1:0] pin_r;
    logic [PIN_W-1:0] pinIdle;

    // Reset loads each pin's idle level. The acknowledge bits take their
    // inactive level, so no grant can show before the pins are seen.
    always_comb begin
        pinIdle           = PIN_RST;
        pinIdle[PIN_ACK1] = ~hcAckHigh;
        pinIdle[PIN_ACK2] = ~dcAckHigh;
    end

    function automatic logic [PIN_W-1:0] agree(
        input logic [PIN_W-1:0] a,
        input logic [PIN_W-1:0] b,
        input logic [PIN_W-1:0] hold);
        agree = (a & b) | (hold & (a ^ b));
    endfunction : agree

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            s1_r  <= pinIdle;
            s2_r  <= pinIdle;
            s3_r  <= pinIdle;
            pin_r <= pinIdle;
        end else begin
            s1_r  <= {busIn, dmaAck2, dmaAck1, writeN, readN, chipSelN};
            s2_r  <= s1_r;
            s3_r  <= s2_r;
            pin_r <= agree(s2_r, s3_r, pin_r);
        end
    end

    // =========================================================================
    // Access decode; strobes count only under chip select.
    wire              selected = ~pin_r[PIN_CS];
    wire              rdActive = selected & ~pin_r[PIN_RD];
    wire              wrActive = selected & ~pin_r[PIN_WR];
    wire [DATA_W-1:0] pinData  = pin_r[PIN_DATA +: DATA_W];

    bus_state_t state_r;
    bus_state_t state_nxt;
    logic       fifoInReady;
    wire        rdStart = (state_r == BUS_IDLE) & rdActive;
    // Data is sampled in the cycle the strobe is first seen, through the same synchroniser, so it is stable.
    wire        wrStart = (state_r == BUS_IDLE) & wrActive & ~rdActive;
    wire        push    = wrStart & fifoInReady;

    always_comb begin
        state_nxt = state_r;
        case (state_r)
            BUS_IDLE: begin
                if (rdActive) begin
                    state_nxt = BUS_READ;
                end else if (wrActive) begin
                    state_nxt = BUS_WRITE;
                end
            end
            BUS_READ: begin
                if (!rdActive) begin
                    state_nxt = BUS_IDLE;
                end
            end
            BUS_WRITE: begin
                if (!wrActive) begin
                    state_nxt = BUS_IDLE;
                end
            end
            default: state_nxt = BUS_IDLE;
        endcase
    end

    logic [DATA_W-1:0] busOut_r;
    logic              busOe_r;
    logic              rdTaken_r;
    logic              wrOverflow_r;
    logic              wrSpace_r;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state_r      <= BUS_IDLE;
            busOut_r     <= DATA_RST;
            busOe_r      <= 1'b0;
            rdTaken_r    <= 1'b0;
            wrOverflow_r <= 1'b0;
            wrSpace_r    <= 1'b0;
        end else begin
            state_r      <= state_nxt;
            busOe_r      <= (state_nxt == BUS_READ);
            rdTaken_r    <= rdStart;
            wrSpace_r    <= fifoInReady;
            // A write to a full FIFO is lost; the sticky flag reports it.
            wrOverflow_r <= wrOverflow_r | (wrStart & ~fifoInReady);
            if (rdStart) begin
                busOut_r <= rdData;
            end
        end
    end

    hbd_fifo #(
        .WIDTH (DATA_W),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk      (clk),
        .rst_n    (rst_n),
        .inValid  (wrStart),
        .inReady  (fifoInReady),
        .inData   (pinData),
        .outValid (wrValid),
        .outReady (wrReady),
        .outData  (wrData)
    );

    // =========================================================================
    // DMA request and acknowledge routing.
    wire ack1On  = (pin_r[PIN_ACK1] == hcAckHigh);
    wire ack2On  = (pin_r[PIN_ACK2] == dcAckHigh);
    wire need1   = sharedDma ? (hcNeed | dcNeed) : hcNeed;
    wire need2   = ~sharedDma & dcNeed;

    logic dmaReq1_r;
    logic dmaReq2_r;
    logic hcGrant_r;
    logic dcGrant_r;
    logic ownerDc_r;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            dmaReq1_r <= 1'b0;
            dmaReq2_r <= 1'b0;
            hcGrant_r <= 1'b0;
            dcGrant_r <= 1'b0;
            ownerDc_r <= 1'b0;
        end else begin
            dmaReq1_r <= need1 ? hcReqHigh : ~hcReqHigh;
            dmaReq2_r <= need2 ? dcReqHigh : ~dcReqHigh;
            // The shared channel owner is frozen while the first acknowledge is active,
            // so an acknowledge never switches controllers mid-burst.
            if (!ack1On) begin
                ownerDc_r <= ~hcNeed & dcNeed;
            end
            hcGrant_r <= ack1On & ~(sharedDma & ownerDc_r);
            dcGrant_r <= sharedDma ? ack1On & ownerDc_r : ack2On;
        end
    end

    assign busOut     = busOut_r;
    assign busOe      = busOe_r;
    assign rdTaken    = rdTaken_r;
    assign wrSpace    = wrSpace_r;
    assign wrOverflow = wrOverflow_r;
    assign dmaReq1    = dmaReq1_r;
    assign dmaReq2    = dmaReq2_r;
    assign hcGrant    = hcGrant_r;
    assign dcGrant    = dcGrant_r;

    // =========================================================================
    // Assertions
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    property p_idleUndriven;
        !rdActive |=> !busOe;
    endproperty
    a_idleUndriven: assert property (p_idleUndriven)
        else $error("Data bus driven with no read in progress");

    property p_readDrives;
        rdStart |=> busOe && busOut == $past(rdData);
    endproperty
    a_readDrives: assert property (p_readDrives)
        else $error("Read did not drive the sampled word");

    property p_csIgnored;
        pin_r[PIN_CS] |=> !busOe && !rdTaken;
    endproperty
    a_csIgnored: assert property (p_csIgnored)
        else $error("Strobe acted without chip select");

    property p_writeStored;
        push && !wrValid && !wrReady |=> wrValid && wrData == $past(pinData);
    endproperty
    a_writeStored: assert property (p_writeStored)
        else $error("Written word not in FIFO");

    property p_req1Level;
        rst_n |=> dmaReq1 == ($past(need1) ~^ $past(hcReqHigh));
    endproperty
    a_req1Level: assert property (p_req1Level)
        else $error("First request at wrong level");

    property p_sharedRoute;
        rst_n && sharedDma && dcNeed |=> dmaReq1 == $past(hcReqHigh)
            && dmaReq2 == !$past(dcReqHigh);
    endproperty
    a_sharedRoute: assert property (p_sharedRoute)
        else $error("Shared channel not routed to first pair");

    property p_req2Level;
        rst_n && !sharedDma && dcNeed |=> dmaReq2 == $past(dcReqHigh);
    endproperty
    a_req2Level: assert property (p_req2Level)
        else $error("Second request not asserted");

    property p_independent;
        rst_n && !sharedDma |=> dcGrant == $past(ack2On)
            && hcGrant == $past(ack1On);
    endproperty
    a_independent: assert property (p_independent)
        else $error("Independent channels crossed");

    c_read:   cover property (rdStart ##[1:20] !busOe);
    c_write:  cover property (push ##1 wrValid);
    c_shared: cover property (sharedDma && ack1On ##1 dcGrant);
    c_full:   cover property (wrStart && !fifoInReady);

endmodule : host_bus_dma_request_port

// *** shared/hbd_pkg.sv ***
// Constants and types shared by the host data port and its write FIFO.
package hbd_pkg;

    // =========================================================================
    // Widths and depths
    localparam int DATA_W     = 16;
    localparam int FIFO_DEPTH = 8;

    // =========================================================================
    // Positions inside the synchronised pin vector
    localparam int PIN_CS     = 0;
    localparam int PIN_RD     = 1;
    localparam int PIN_WR     = 2;
    localparam int PIN_ACK1   = 3;
    localparam int PIN_ACK2   = 4;
    localparam int PIN_DATA   = 5;
    localparam int PIN_W      = PIN_DATA + DATA_W;

    // =========================================================================
    // Reset values
    localparam logic [PIN_W-1:0]  PIN_RST  = 21'h1f_ffff;
    localparam logic [DATA_W-1:0] DATA_RST = 16'h0000;

    typedef enum logic [1:0] {
        BUS_IDLE  = 2'b00,
        BUS_READ  = 2'b01,
        BUS_WRITE = 2'b10
    } bus_state_t;

endpackage : hbd_pkg

// *** sim/host_cpu_model.sv ***
// Microprocessor and DMA controller model facing the host data port.
module host_cpu_model
    import hbd_pkg::*;
(
    input  wire logic                       clk,      // System clock.
    input  wire logic [hbd_pkg::DATA_W-1:0] busOut,   // Device data drive.
    input  wire logic                       busOe,    // Device drives data.
    output logic      [hbd_pkg::DATA_W-1:0] busIn,    // Resolved data pins.
    output logic                            chipSelN, // Chip select, low.
    output logic                            readN,    // Read strobe, low.
    output logic                            writeN,   // Write strobe, low.
    output logic                            dmaAck1,  // First ack pin.
    output logic                            dmaAck2   // Second ack pin.
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [DATA_W-1:0] hostDrv = 16'h0000;
    // A released bus has no pull, so it shows the inverse of the last word.
    assign busIn = busOe ? busOut : hostDrv;
    initial begin
        chipSelN = 1'b1;
        readN    = 1'b1;
        writeN   = 1'b1;
        dmaAck1  = 1'b0;
        dmaAck2  = 1'b0;
    end
    task automatic write_word(input logic csN, input logic [DATA_W-1:0] d);
        hostDrv <= d;
        repeat (3) @(posedge clk);
        chipSelN <= csN;
        writeN   <= 1'b0;
        repeat (6) @(posedge clk);
        chipSelN <= 1'b1;
        writeN   <= 1'b1;
        hostDrv  <= ~d;
        repeat (6) @(posedge clk);
    endtask : write_word
    task automatic read_word(input logic csN, output logic [DATA_W-1:0] d,
                             output logic seen);
        int n;
        n = 0;
        d = 16'h0000;
        seen = 1'b0;
        chipSelN <= csN;
        readN    <= 1'b0;
        while (n < 12 && !seen) begin
            @(posedge clk);
            n++;
            seen = (busOe === 1'b1);
            d = busOut;
        end
        chipSelN <= 1'b1;
        readN    <= 1'b1;
        hostDrv  <= ~d;
        repeat (8) @(posedge clk);
    endtask : read_word
    task automatic ack(input logic a1, input logic a2);
        dmaAck1 <= a1;
        dmaAck2 <= a2;
    endtask : ack
endmodule : host_cpu_model

// *** sim/tb.sv ***
// Self-checking testbench of the host data port.
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import hbd_pkg::*;
    logic clk = 1'b0;
    logic rst_n, wrReady, hcNeed, dcNeed, sharedDma, hcReqHigh, hcAckHigh;
    logic dcReqHigh, dcAckHigh, busOe, chipSelN, readN, writeN, rdTaken;
    logic wrValid, wrSpace, wrOverflow, dmaAck1, dmaAck2, dmaReq1, dmaReq2;
    logic hcGrant, dcGrant, seen, n1, n2, ah;
    logic [DATA_W-1:0] busIn, busOut, rdData, wrData, got;
    logic [7:0] grantTab [6] = '{8'hba, 8'hb5, 8'h3f, 8'hd9, 8'h6a, 8'hd4};
    int err_total = 0;
    int checked = 0;
    int takes = 0;
    host_bus_dma_request_port u_dut (.clk(clk), .rst_n(rst_n), .busIn(busIn),
        .busOut(busOut), .busOe(busOe), .chipSelN(chipSelN), .readN(readN),
        .writeN(writeN), .rdData(rdData), .rdTaken(rdTaken),
        .wrValid(wrValid), .wrReady(wrReady), .wrData(wrData),
        .wrSpace(wrSpace), .wrOverflow(wrOverflow), .hcNeed(hcNeed),
        .dcNeed(dcNeed), .sharedDma(sharedDma), .hcReqHigh(hcReqHigh),
        .hcAckHigh(hcAckHigh), .dcReqHigh(dcReqHigh), .dcAckHigh(dcAckHigh),
        .dmaAck1(dmaAck1), .dmaAck2(dmaAck2), .dmaReq1(dmaReq1),
        .dmaReq2(dmaReq2), .hcGrant(hcGrant), .dcGrant(dcGrant));
    host_cpu_model u_host (.clk(clk), .busOut(busOut), .busOe(busOe),
        .busIn(busIn), .chipSelN(chipSelN), .readN(readN), .writeN(writeN),
        .dmaAck1(dmaAck1), .dmaAck2(dmaAck2));
    always #2.5 clk = ~clk;
    always @(posedge clk) begin
        if (rdTaken === 1'b1) begin
            takes++;
        end
    end
    // ====================================================================
    // Compare and verdict
    task automatic chk(input logic [DATA_W-1:0] g, input logic [DATA_W-1:0] e,
                       input string m);
        checked++;
        if (g !== e) begin
            err_total++;
            $display("MISMATCH %0t %s", $time, m);
        end
    endtask : chk
    task automatic chkBit(input logic g, input logic e, input string m);
        chk({15'h0000, g}, {15'h0000, e}, m);
    endtask : chkBit
    task automatic give_verdict;
        $display("Comparisons %0d, mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : give_verdict
    // ====================================================================
    // Tests
    initial begin
        {rst_n, wrReady, hcNeed, dcNeed, sharedDma} = 5'h00;
        {hcReqHigh, hcAckHigh, dcReqHigh, dcAckHigh} = 4'hf;
        rdData = 16'h0000;
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        repeat (2) @(posedge clk);
        chkBit(busOe, 1'b0, "bus driven after reset");
        u_host.write_word(1'b1, 16'ha5a5);
        chkBit(wrValid, 1'b0, "write taken without select");
        u_host.read_word(1'b1, got, seen);
        chkBit(seen, 1'b0, "bus driven without select");
        // Sink stalls so the buffer fills and then refuses one word.
        for (int i = 0; i < FIFO_DEPTH; i++) begin
            u_host.write_word(1'b0, 16'h1000 + 16'(i));
        end
        chkBit(wrSpace, 1'b0, "buffer not full");
        chkBit(wrOverflow, 1'b0, "early overflow");
        u_host.write_word(1'b0, 16'hdead);
        chkBit(wrOverflow, 1'b1, "overflow not flagged");
        for (int i = 0; i < FIFO_DEPTH; i++) begin
            chkBit(wrValid, 1'b1, "buffer empty too soon");
            chk(wrData, 16'h1000 + 16'(i), "written word order");
            wrReady <= 1'b1;
            @(posedge clk);
            wrReady <= 1'b0;
            @(posedge clk);
        end
        chkBit(wrValid, 1'b0, "buffer not empty");
        chkBit(wrSpace, 1'b1, "no room after drain");
        // Two reads, eight idle cycles apart, exercise all sixteen lines, upper ones too.
        for (int i = 0; i < 2; i++) begin
            rdData <= (i == 0) ? 16'h0ff0 : 16'hf00f;
            u_host.read_word(1'b0, got, seen);
            chk(got, (i == 0) ? 16'h0ff0 : 16'hf00f, "read word");
            chkBit(busOe, 1'b0, "bus not released");
        end
        chk(16'(takes), 16'h0002, "read start count");
        // Every mode and need combination of the request pins, both polarities, with dcReqHigh always opposite to hcReqHigh.
        for (int k = 0; k < 16; k++) begin
            {sharedDma, hcReqHigh, hcNeed, dcNeed} <= 4'(k);
            dcReqHigh <= ~k[2];
            repeat (3) @(posedge clk);
            n1 = hcNeed | (sharedDma & dcNeed);
            n2 = dcNeed & ~sharedDma;
            chkBit(dmaReq1, n1 ~^ hcReqHigh, "req1");
            chkBit(dmaReq2, n2 ~^ dcReqHigh, "req2");
        end
        // Grants follow the acknowledge routing of each mode.
        foreach (grantTab[r]) begin
            ah = grantTab[r][7];
            {hcAckHigh, dcAckHigh} <= {ah, ah};
            {sharedDma, hcNeed, dcNeed} <= grantTab[r][6:4];
            u_host.ack(~ah, ~ah);
            repeat (8) @(posedge clk);
            u_host.ack(grantTab[r][3] ~^ ah, grantTab[r][2] ~^ ah);
            repeat (8) @(posedge clk);
            chkBit(hcGrant, grantTab[r][1], "hc grant");
            chkBit(dcGrant, grantTab[r][0], "dc grant");
            u_host.ack(~ah, ~ah);
        end
        repeat (8) @(posedge clk);
        give_verdict();
    end
    initial begin
        repeat (20000) @(posedge clk);
        err_total++;
        give_verdict();
    end
endmodule : tb
